// file: rtl/apsr_top.sv
// axis position counters, rates, pin levels and stop-cause readout
//
// The strobed register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
// Contract
// - signed 32-bit commanded position, load and read
// - signed 32-bit encoder position, preset and read
// - preset by axis mask, read one axis
// - report present speed in pulses per second
// - report present acceleration, pulses per second squared
// - single-signal query by selector zero to nine
// - 16-bit raw pin word, one is high
// - pin word bit placement as fixed
// - emergency bit only on the X word
// - module flag when any cause nonzero
// - cause code is sum of weights
// - weights 1, 2 are software limits
// - weights 4, 8 are hardware limits
// - 16 alarm, 32 emergency, 64 never
// - 128 when index and home together
// - 256 marks software stop command
module apsr_top
    import apsr_pkg::*;
(
    input  wire logic          i_sys_clk,     // system clock, 50 MHz
    input  wire logic          i_rst_n,       // async reset, active low
    input  wire logic [7:0]    i_addr,        // register word index
    input  wire logic [31:0]   i_wdata,       // write data
    input  wire logic          i_wr,          // write strobe
    input  wire logic          i_rd,          // read strobe
    output logic      [31:0]   o_rdata,       // read data, cycle after read
    input  wire logic          i_emerg,       // module emergency level
    input  wire apsr_axis_in_t i_ax_x,        // x axis inputs
    input  wire apsr_axis_in_t i_ax_y,        // y axis inputs
    output logic               o_error_any,   // any axis cause nonzero
    output logic      [1:0]    o_stop_req,    // per-axis software stop
    output logic               o_irq          // level interrupt
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    apsr_state_t   s_q;
    apsr_state_t   s_d;
    apsr_axis_in_t ain [NUM_AXES];
    logic [15:0]   pins  [NUM_AXES];
    logic [15:0]   cause [NUM_AXES];
    logic [NUM_AXES-1:0] cnz;
    logic [IRQ_BITS-1:0] ev;

    assign ain[0] = i_ax_x;
    assign ain[1] = i_ax_y;

    // ------------------------------------------------------------------
    // per-axis pin word and cause code
    // ------------------------------------------------------------------
    always_comb begin
        for (int a = 0; a < NUM_AXES; a++) begin
            pins[a] = RST_WORD;
            pins[a][P_NEAR]  = ain[a].near_origin_input;
            pins[a][P_HOME]  = ain[a].home;
            pins[a][P_INDEX] = ain[a].index;
            pins[a][P_EMERG] = (a == 0) ? i_emerg : 1'b0;
            pins[a][P_EXTP]  = ain[a].ext_pulse_pos_input;
            pins[a][P_EXTN]  = ain[a].ext_pulse_neg_input;
            pins[a][P_IN_POSITION_INPUT] = ain[a].in_position_input;
            pins[a][P_ALARM] = ain[a].alarm;
            pins[a][P_SPARE] = ain[a].spare_input_three;
            pins[a][P_FWD]   = ain[a].fwd_limit_input;
            pins[a][P_REV]   = ain[a].rev_limit_input;
            cause[a] = RST_WORD;
            cause[a][C_SOFT_FWD] = ain[a].soft_fwd;
            cause[a][C_SOFT_REV] = ain[a].soft_rev;
            cause[a][C_HARD_FWD] = ain[a].fwd_limit_input;
            cause[a][C_HARD_REV] = ain[a].rev_limit_input;
            // alarm and emergency; 64 stays zero
            cause[a][C_ALARM]    = ain[a].alarm;
            cause[a][C_EMERG]    = i_emerg;
            cause[a][C_HOME]     = ain[a].index & ain[a].home;
            cause[a][C_SW_STOP]  = s_q.ax[a].sw_stop;
            cnz[a] = |cause[a];
        end
    end

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [1:0]  qa;
        logic        qv;
        logic [31:0] r;
        s_d = s_q;
        qa  = 2'b00;
        qv  = 1'b0;
        r   = 32'h0000_0000;

        // counters follow the motion core unless preset
        for (int a = 0; a < NUM_AXES; a++) begin
            if (ain[a].cmd_step) begin
                s_d.ax[a].commanded_position_count =
                    ain[a].cmd_dir ? s_q.ax[a].commanded_position_count - 1
                                   : s_q.ax[a].commanded_position_count + 1;
            end
            if (ain[a].enc_step) begin
                s_d.ax[a].encoder_position_count =
                    ain[a].enc_dir ? s_q.ax[a].encoder_position_count - 1
                                   : s_q.ax[a].encoder_position_count + 1;
            end
        end

        // register writes
        if (i_wr) begin
            case (i_addr)
                A_AXIS_SEL:  s_d.axis_sel  = i_wdata[1:0];
                A_QUERY_SEL: s_d.query_sel = i_wdata[3:0];
                A_IRQ_MASK:  s_d.irq_mask  = i_wdata[IRQ_BITS-1:0];
                A_IRQ_STAT:  s_d.irq_stat  = s_q.irq_stat
                                             & ~i_wdata[IRQ_BITS-1:0];
                A_SET_CMD: begin
                    for (int a = 0; a < NUM_AXES; a++) begin
                        if (s_q.axis_sel[a]) begin
                            s_d.ax[a].commanded_position_count = i_wdata;
                        end
                    end
                end
                A_SET_ENC: begin
                    for (int a = 0; a < NUM_AXES; a++) begin
                        if (s_q.axis_sel[a]) begin
                            s_d.ax[a].encoder_position_count = i_wdata;
                        end
                    end
                end
                A_SW_STOP: begin
                    for (int a = 0; a < NUM_AXES; a++) begin
                        if (i_wdata[a]) begin
                            s_d.ax[a].sw_stop = 1'b1;
                        end
                    end
                end
                A_CLR_STOP: begin
                    for (int a = 0; a < NUM_AXES; a++) begin
                        if (i_wdata[a]) begin
                            s_d.ax[a].sw_stop = 1'b0;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // single-signal query, y axis only when selection has bit 1 alone, else x
        // selector zero to nine
        qa = s_q.axis_sel[1] & ~s_q.axis_sel[0] ? 2'd1 : 2'd0;
        case (apsr_query_t'(s_q.query_sel))
            Q_MOVING: qv = ain[qa[0]].moving;
            Q_FWD:    qv = ain[qa[0]].fwd_limit_input;
            Q_REV:    qv = ain[qa[0]].rev_limit_input;
            Q_EMERG:  qv = i_emerg;
            Q_ALARM:  qv = ain[qa[0]].alarm;
            Q_HOME:   qv = ain[qa[0]].home;
            Q_NEAR:   qv = ain[qa[0]].near_origin_input;
            Q_SPARE:  qv = ain[qa[0]].spare_input_three;
            Q_IN_POSITION_INPUT:  qv = ain[qa[0]].in_position_input;
            Q_INDEX:  qv = ain[qa[0]].index;
            default:  qv = 1'b0;
        endcase

        // register reads, one axis per address
        if (i_rd) begin
            case (i_addr)
                A_CMD_POS_X: r = s_q.ax[0].commanded_position_count;
                A_CMD_POS_Y: r = s_q.ax[1].commanded_position_count;
                A_ENC_POS_X: r = s_q.ax[0].encoder_position_count;
                A_ENC_POS_Y: r = s_q.ax[1].encoder_position_count;
                A_SPEED_X:   r = ain[0].present_speed;
                A_SPEED_Y:   r = ain[1].present_speed;
                A_ACCEL_X:   r = ain[0].present_accel;
                A_ACCEL_Y:   r = ain[1].present_accel;
                A_PINS_X:    r = {16'h0000, pins[0]};
                A_PINS_Y:    r = {16'h0000, pins[1]};
                A_CAUSE_X:   r = {16'h0000, cause[0]};
                A_CAUSE_Y:   r = {16'h0000, cause[1]};
                A_ERR_ANY:   r = {31'h0000_0000, s_q.err_any};
                A_AXIS_SEL:  r = {30'h0000_0000, s_q.axis_sel};
                A_QUERY_SEL: r = {28'h000_0000, s_q.query_sel};
                A_QUERY_ANS: r = {31'h0000_0000, qv};
                A_IRQ_STAT:  r = {29'h0000_0000, s_q.irq_stat};
                A_IRQ_MASK:  r = {29'h0000_0000, s_q.irq_mask};
                default:     r = 32'h0000_0000;
            endcase
        end
        s_d.rdata = r;

        s_d.err_any  = |cnz;
        s_d.cause_nz = cnz;

        // events: axis cause rises, then set wins over clear
        ev = {1'b0, cnz & ~s_q.cause_nz};
        ev[2] = |cnz & ~s_q.err_any;
        s_d.irq_stat = s_d.irq_stat | ev;
        s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int a = 0; a < NUM_AXES; a++) begin
                s_q.ax[a].commanded_position_count <= RST_POS;
                s_q.ax[a].encoder_position_count   <= RST_POS;
                s_q.ax[a].sw_stop                  <= 1'b0;
            end
            s_q.axis_sel  <= RST_SEL;
            s_q.query_sel <= RST_QSEL;
            s_q.rdata     <= RST_POS;
            s_q.irq_stat  <= '0;
            s_q.irq_mask  <= '0;
            s_q.irq       <= 1'b0;
            s_q.err_any   <= 1'b0;
            s_q.cause_nz  <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign o_rdata     = s_q.rdata;
    assign o_error_any = s_q.err_any;
    assign o_irq       = s_q.irq;
    always_comb begin
        for (int a = 0; a < NUM_AXES; a++) begin
            o_stop_req[a] = s_q.ax[a].sw_stop;
        end
    end

endmodule // apsr_top

// file: rtl/apsr_pkg.sv
// constants and types for the axis position and status readout block
package apsr_pkg;

    // ------------------------------------------------------------------
    // register offsets (word index on the plain register port)
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CMD_POS_X  = 8'h00;
    localparam logic [7:0] A_CMD_POS_Y  = 8'h01;
    localparam logic [7:0] A_ENC_POS_X  = 8'h02;
    localparam logic [7:0] A_ENC_POS_Y  = 8'h03;
    localparam logic [7:0] A_SPEED_X    = 8'h04;
    localparam logic [7:0] A_SPEED_Y    = 8'h05;
    localparam logic [7:0] A_ACCEL_X    = 8'h06;
    localparam logic [7:0] A_ACCEL_Y    = 8'h07;
    localparam logic [7:0] A_PINS_X     = 8'h08;
    localparam logic [7:0] A_PINS_Y     = 8'h09;
    localparam logic [7:0] A_CAUSE_X    = 8'h0A;
    localparam logic [7:0] A_CAUSE_Y    = 8'h0B;
    localparam logic [7:0] A_ERR_ANY    = 8'h0C;
    localparam logic [7:0] A_AXIS_SEL   = 8'h0D;
    localparam logic [7:0] A_SET_CMD    = 8'h0E;
    localparam logic [7:0] A_SET_ENC    = 8'h0F;
    localparam logic [7:0] A_QUERY_SEL  = 8'h10;
    localparam logic [7:0] A_QUERY_ANS  = 8'h11;
    localparam logic [7:0] A_CLR_STOP   = 8'h12;
    localparam logic [7:0] A_SW_STOP    = 8'h13;
    localparam logic [7:0] A_IRQ_STAT   = 8'h14;
    localparam logic [7:0] A_IRQ_MASK   = 8'h15;

    // ------------------------------------------------------------------
    // pin-level word bit positions
    // ------------------------------------------------------------------
    localparam int P_NEAR  = 0;
    localparam int P_HOME  = 1;
    localparam int P_INDEX = 2;
    localparam int P_EMERG = 3;
    localparam int P_EXTP  = 4;
    localparam int P_EXTN  = 5;
    localparam int P_IN_POSITION_INPUT = 6;
    localparam int P_ALARM = 7;
    localparam int P_SPARE = 11;
    localparam int P_FWD   = 14;
    localparam int P_REV   = 15;

    // ------------------------------------------------------------------
    // stop-cause bit positions (weight = 2**position)
    // ------------------------------------------------------------------
    localparam int C_SOFT_FWD = 0;
    localparam int C_SOFT_REV = 1;
    localparam int C_HARD_FWD = 2;
    localparam int C_HARD_REV = 3;
    localparam int C_ALARM    = 4;
    localparam int C_EMERG    = 5;
    localparam int C_HOME     = 7;
    localparam int C_SW_STOP  = 8;

    // ------------------------------------------------------------------
    // reset values and misc widths
    // ------------------------------------------------------------------
    localparam logic [31:0] RST_POS   = 32'h0000_0000;
    localparam logic [15:0] RST_WORD  = 16'h0000;
    localparam logic [1:0]  RST_SEL   = 2'h0;
    localparam logic [3:0]  RST_QSEL  = 4'h0;
    localparam int          NUM_AXES  = 2;
    localparam int          IRQ_BITS  = 3;

    // query selector codes
    typedef enum logic [3:0] {
        Q_MOVING = 4'h0, Q_FWD   = 4'h1, Q_REV   = 4'h2, Q_EMERG = 4'h3,
        Q_ALARM  = 4'h4, Q_HOME  = 4'h5, Q_NEAR  = 4'h6, Q_SPARE = 4'h7,
        Q_IN_POSITION_INPUT  = 4'h8, Q_INDEX = 4'h9
    } apsr_query_t;

    // per-axis raw inputs from the motion core and pins
    typedef struct packed {
        logic        moving;
        logic        soft_fwd;
        logic        soft_rev;
        logic        fwd_limit_input;
        logic        rev_limit_input;
        logic        alarm;
        logic        home;
        logic        near_origin_input;
        logic        index;
        logic        in_position_input;
        logic        spare_input_three;
        logic        ext_pulse_pos_input;
        logic        ext_pulse_neg_input;
        logic [31:0] present_speed;
        logic [31:0] present_accel;
        logic        cmd_step;       // commanded position advance
        logic        cmd_dir;        // 1 = count down
        logic        enc_step;       // encoder count advance
        logic        enc_dir;        // 1 = count down
    } apsr_axis_in_t;

    // per-axis kept state
    typedef struct packed {
        logic [31:0] commanded_position_count;
        logic [31:0] encoder_position_count;
        logic        sw_stop;
    } apsr_axis_st_t;

    // whole module state
    typedef struct packed {
        apsr_axis_st_t [NUM_AXES-1:0] ax;
        logic [1:0]          axis_sel;
        logic [3:0]          query_sel;
        logic [31:0]         rdata;
        logic [IRQ_BITS-1:0] irq_stat;
        logic [IRQ_BITS-1:0] irq_mask;
        logic                irq;
        logic                err_any;
        logic [NUM_AXES-1:0] cause_nz;
    } apsr_state_t;

endpackage : apsr_pkg

// file: verification/apsr_top_chk.sv
// port assertions for the axis readout block
`timescale 1ns/1ps
module apsr_top_chk
    import apsr_pkg::*;
(
    input wire logic          i_sys_clk,   // clock
    input wire logic          i_rst_n,     // reset, active low
    input wire logic [7:0]    i_addr,      // word index
    input wire logic [31:0]   i_wdata,     // write data
    input wire logic          i_wr,        // write strobe
    input wire logic          i_rd,        // read strobe
    input wire logic [31:0]   o_rdata,     // read data
    input wire logic          i_emerg,     // emergency level
    input wire apsr_axis_in_t i_ax_x,      // x inputs
    input wire apsr_axis_in_t i_ax_y,      // y inputs
    input wire logic          o_error_any, // any cause flag
    input wire logic [1:0]    o_stop_req,  // stop pending
    input wire logic          o_irq        // interrupt
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);
    // expected pin word from live levels
    function automatic logic [15:0] pins(apsr_axis_in_t a, logic e);
        return {a.rev_limit_input, a.fwd_limit_input, 2'h0,
                a.spare_input_three, 3'h0, a.alarm, a.in_position_input,
                a.ext_pulse_neg_input, a.ext_pulse_pos_input, e,
                a.index, a.home, a.near_origin_input};
    endfunction
    // expected cause code, weight 64 never set
    function automatic logic [31:0] cause(apsr_axis_in_t a, logic e,
                                          logic s);
        return {23'h0, s, a.index & a.home, 1'h0, e, a.alarm,
                a.rev_limit_input, a.fwd_limit_input, a.soft_rev,
                a.soft_fwd};
    endfunction
    property p_pins_x;
        i_rd && i_addr == A_PINS_X |=>
            o_rdata == {16'h0, $past(pins(i_ax_x, i_emerg))};
    endproperty
    a_pins_x: assert property (p_pins_x)
        else $error("pin word x mismatch");
    property p_pins_y;
        i_rd && i_addr == A_PINS_Y |=>
            o_rdata == {16'h0, $past(pins(i_ax_y, 1'b0))};
    endproperty
    a_pins_y: assert property (p_pins_y)
        else $error("pin word y mismatch");
    property p_speed;
        i_rd && i_addr == A_SPEED_X |=>
            o_rdata == $past(i_ax_x.present_speed);
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed readout mismatch");
    property p_accel;
        i_rd && i_addr == A_ACCEL_Y |=>
            o_rdata == $past(i_ax_y.present_accel);
    endproperty
    a_accel: assert property (p_accel)
        else $error("accel readout mismatch");
    property p_cause;
        i_rd && i_addr == A_CAUSE_Y |=>
            o_rdata == $past(cause(i_ax_y, i_emerg, o_stop_req[1]));
    endproperty
    a_cause: assert property (p_cause)
        else $error("cause code y mismatch");
    property p_err;
        1'b1 |=> o_error_any ==
            ($past(cause(i_ax_x, i_emerg, o_stop_req[0])) != 32'h0 ||
             $past(cause(i_ax_y, i_emerg, o_stop_req[1])) != 32'h0);
    endproperty
    a_err: assert property (p_err)
        else $error("error flag mismatch");
    property p_stop_set;
        i_wr && i_addr == A_SW_STOP |=>
            o_stop_req == ($past(o_stop_req) | $past(i_wdata[1:0]));
    endproperty
    a_stop_set: assert property (p_stop_set)
        else $error("software stop not latched");
    property p_stop_hold;
        !(i_wr && (i_addr == A_SW_STOP || i_addr == A_CLR_STOP)) |=>
            $stable(o_stop_req);
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stop state changed unasked");
    property p_stop_clr;
        i_wr && i_addr == A_CLR_STOP |=>
            o_stop_req == ($past(o_stop_req) & ~$past(i_wdata[1:0]));
    endproperty
    a_stop_clr: assert property (p_stop_clr)
        else $error("clear stop mismatch");
    c_stop: cover property (o_stop_req != 2'h0);
    c_err: cover property ($rose(o_error_any));
    c_irq: cover property ($rose(o_irq));
endmodule // apsr_top_chk

bind apsr_top apsr_top_chk apsr_top_chk_i (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_emerg(i_emerg), .i_ax_x(i_ax_x), .i_ax_y(i_ax_y),
    .o_error_any(o_error_any), .o_stop_req(o_stop_req), .o_irq(o_irq)
);

// file: verification/apsr_axis_model.sv
// motion core and pin model feeding one axis
`timescale 1ns/1ps
module apsr_axis_model
    import apsr_pkg::*;
#(
    parameter logic [31:0] SPEED = 32'h0000_1000, // output rate, pps
    parameter logic [31:0] ACCEL = 32'h0000_0100  // rate change, pps/s
)(
    input  wire logic [12:0] i_lvl,   // pin and limit levels
    input  wire logic        i_cstep, // commanded count pulse
    input  wire logic        i_estep, // encoder count pulse
    input  wire logic        i_dir,   // 1 counts down
    output apsr_axis_in_t    o_ax     // packed axis inputs
);
    // levels driven high when asserted, rates fixed by SPEED and ACCEL
    always_comb begin
        o_ax = '0;
        {o_ax.soft_rev, o_ax.soft_fwd, o_ax.ext_pulse_neg_input,
         o_ax.ext_pulse_pos_input, o_ax.index, o_ax.in_position_input,
         o_ax.spare_input_three, o_ax.near_origin_input, o_ax.home,
         o_ax.alarm, o_ax.rev_limit_input, o_ax.fwd_limit_input,
         o_ax.moving} = i_lvl;
        o_ax.present_speed = SPEED;
        o_ax.present_accel = ACCEL;
        o_ax.cmd_step = i_cstep;
        o_ax.enc_step = i_estep;
        o_ax.cmd_dir = i_dir;
        o_ax.enc_dir = i_dir;
    end
endmodule // apsr_axis_model

// file: verification/apsr_top_bench.sv
// register-level bench for the axis readout block
`timescale 1ns/1ps
module apsr_top_bench;
    import apsr_pkg::*;
    localparam logic [31:0] SPD_X = 32'h0001_86A0, SPD_Y = 32'h0000_4E20;
    localparam logic [31:0] ACC_X = 32'h0000_3A98, ACC_Y = 32'h0000_07D0;
    logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic i_emerg = 1'b0, cstep = 1'b0, estep = 1'b0, dir = 1'b0;
    logic [7:0] i_addr = 8'h00;
    logic [31:0] i_wdata = 32'h0000_0000, o_rdata;
    logic [12:0] lvl_x = 13'h0, lvl_y = 13'h0;
    logic o_error_any, o_irq;
    logic [1:0] o_stop_req;
    apsr_axis_in_t ax_x, ax_y;
    int error_cnt = 0, compares = 0;
    int lv [7] = '{12'h800, 13'h1000, 2, 4, 8, 13'h110, 13'h10};
    int em [7] = '{0, 0, 0, 0, 1, 0, 0};
    int cx [7] = '{1, 2, 4, 8, 48, 128, 0};
    always #10 i_sys_clk = ~i_sys_clk;
    apsr_axis_model #(.SPEED(SPD_X), .ACCEL(ACC_X)) apsr_axis_model_i (
        .i_lvl(lvl_x), .i_cstep(cstep), .i_estep(estep), .i_dir(dir),
        .o_ax(ax_x));
    apsr_axis_model #(.SPEED(SPD_Y), .ACCEL(ACC_Y)) apsr_axis_model_y_i (
        .i_lvl(lvl_y), .i_cstep(1'b0), .i_estep(1'b0), .i_dir(1'b0),
        .o_ax(ax_y));
    apsr_top apsr_top_i (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_emerg(i_emerg), .i_ax_x(ax_x), .i_ax_y(ax_y),
        .o_error_any(o_error_any), .o_stop_req(o_stop_req),
        .o_irq(o_irq));
    // -------------------------------------------------------------
    // compare, bus tasks and closing
    // -------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] s, e);
        compares++;
        if (s !== e) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), o_rdata, e);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        error_cnt++;
        report_and_stop();
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial begin
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd(A_CMD_POS_X, 32'h0000_0000);
        rd(8'hFF, 32'h0000_0000);
        wr(A_AXIS_SEL, 32'h0000_0003);
        wr(A_SET_CMD, 32'h8000_0000);
        rd(A_CMD_POS_Y, 32'h8000_0000);
        wr(A_AXIS_SEL, 32'h0000_0002);
        wr(A_SET_CMD, 32'h7FFF_FFFF);
        rd(A_CMD_POS_X, 32'h8000_0000);
        rd(A_CMD_POS_Y, 32'h7FFF_FFFF);
        wr(A_AXIS_SEL, 32'h0000_0001);
        wr(A_SET_ENC, 32'hFFFF_FFFF);
        rd(A_ENC_POS_Y, 32'h0000_0000);
        @(posedge i_sys_clk);
        cstep <= 1'b1;
        @(posedge i_sys_clk);
        cstep <= 1'b0;
        estep <= 1'b1;
        dir <= 1'b1;
        @(posedge i_sys_clk);
        estep <= 1'b0;
        rd(A_CMD_POS_X, 32'h8000_0001);
        rd(A_ENC_POS_X, 32'hFFFF_FFFE);
        rd(A_SPEED_X, SPD_X);
        rd(A_SPEED_Y, SPD_Y);
        rd(A_ACCEL_X, ACC_X);
        rd(A_ACCEL_Y, ACC_Y);
        for (int q = 0; q < 10; q++) begin
            @(posedge i_sys_clk);
            lvl_x <= (q == 3) ? 13'h0 : 13'h1 << ((q > 3) ? q - 1 : q);
            i_emerg <= (q == 3);
            wr(A_QUERY_SEL, 32'(q));
            rd(A_QUERY_ANS, 32'h0000_0001);
            wr(A_QUERY_SEL, 32'((q + 1) % 10));
            rd(A_QUERY_ANS, 32'h0000_0000);
        end
        @(posedge i_sys_clk);
        lvl_x <= 13'h1FFF;
        lvl_y <= 13'h1FFF;
        i_emerg <= 1'b1;
        wr(A_PINS_X, 32'h0000_0000);
        rd(A_PINS_X, 32'h0000_C8FF);
        rd(A_PINS_Y, 32'h0000_C8F7);
        lvl_y <= 13'h0;
        for (int k = 0; k < 7; k++) begin
            @(posedge i_sys_clk);
            lvl_x <= 13'(lv[k]);
            i_emerg <= em[k][0];
            rd(A_CAUSE_X, 32'(cx[k]));
            rd(A_ERR_ANY, 32'(cx[k] != 0));
        end
        wr(A_AXIS_SEL, 32'h0000_0002);
        wr(A_QUERY_SEL, 32'h0000_0005);
        rd(A_QUERY_ANS, 32'h0000_0000);
        wr(A_AXIS_SEL, 32'h0000_0003);
        rd(A_QUERY_ANS, 32'h0000_0001);
        wr(A_IRQ_MASK, 32'h0000_0000);
        wr(A_IRQ_STAT, 32'h0000_0007);
        wr(A_SW_STOP, 32'h0000_0002);
        rd(A_CAUSE_Y, 32'h0000_0100);
        rd(A_ERR_ANY, 32'h0000_0001);
        chk("irq masked", 32'(o_irq), 32'h0000_0000);
        rd(A_IRQ_STAT, 32'h0000_0006);
        wr(A_IRQ_MASK, 32'h0000_0007);
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk("irq", 32'(o_irq), 32'h0000_0001);
        chk("stop", 32'(o_stop_req), 32'h0000_0002);
        wr(A_CLR_STOP, 32'h0000_0002);
        rd(A_CAUSE_Y, 32'h0000_0000);
        wr(A_IRQ_STAT, 32'h0000_0007);
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk("irq clr", 32'(o_irq), 32'h0000_0000);
        i_rst_n <= 1'b0;
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd(A_CMD_POS_X, 32'h0000_0000);
        rd(A_IRQ_MASK, 32'h0000_0000);
        report_and_stop();
    end
endmodule // apsr_top_bench
